// *** src/fault_resp_cfg.svh ***
// Purpose: constants for the supply fault response block
// Assumes: 250 MHz reference clock
// Notes:   field positions of the per-channel reaction word
`ifndef FAULT_RESP_CFG_SVH
`define FAULT_RESP_CFG_SVH

`define FRC_OFFSET        8'hd9
`define FRC_RESET         32'h0000_0000
`define FRC_RSVD_MASK     32'h0f0f_f7ff
`define FRC_OV_LSB        0
`define FRC_UV_LSB        2
`define FRC_SEQ_LSB       4
`define FRC_OT_LSB        6
`define FRC_FILT_LSB      12
`define FRC_GLOBAL_BIT    14
`define FRC_LOG_BIT       15
`define FRC_ASSERT_LSB    16
`define FRC_RESPOND_LSB   24
`define SEL_VOLT_SEQ      6'h10
`define SEL_VOLT          6'h20
`define SEL_CURR          6'h22
`define CLK_MHZ           250
`define FILT_2MS_MS       2
`define FILT_3MS_MS       3
`define FILT_4MS_MS       4
`define FILT_2MS_CYC      (`FILT_2MS_MS * 1000 * `CLK_MHZ)
`define FILT_3MS_CYC      (`FILT_3MS_MS * 1000 * `CLK_MHZ)
`define FILT_4MS_CYC      (`FILT_4MS_MS * 1000 * `CLK_MHZ)
`define NUM_CH            16
`define NUM_LINES         4

`endif

// *** src/fault_resp_pkg.sv ***
// Purpose: shared types of the supply fault response block
// Assumes: nothing beyond the cfg header
// Notes:   reaction codes follow the two-bit response field
package fault_resp_pkg;
  typedef logic [1:0] reaction_t;
  localparam reaction_t REACT_NONE  = 2'h0;
  localparam reaction_t REACT_LATCH = 2'h1;
  localparam reaction_t REACT_RETRY = 2'h2;
  localparam reaction_t REACT_CONT  = 2'h3;
  typedef enum logic [1:0] {ST_OFF, ST_ON, ST_DELAY, ST_HOLD} ch_state_e;
endpackage

// *** src/excursion_filter.sv ***
// Purpose: persistence filter for one raw excursion
// Assumes: raw input synchronous to ref_clk
// Notes:   counts run at the full clock; long counts are parameters
`include "fault_resp_cfg.svh"
module excursion_filter #(
  parameter int unsigned CYC_2MS = `FILT_2MS_CYC,
  parameter int unsigned CYC_3MS = `FILT_3MS_CYC,
  parameter int unsigned CYC_4MS = `FILT_4MS_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] filt_sel,
  input  wire logic       bypass,
  input  wire logic       raw,
  output logic            declared
);
  logic [20:0] cnt;
  wire  [20:0] limit;
  wire         reached;
  // ------------------------------------------------------------
  // persistence count
  // ------------------------------------------------------------
  // selectable persistence time
  assign limit = (filt_sel == 2'h1) ? 21'(CYC_2MS) :
                 (filt_sel == 2'h2) ? 21'(CYC_3MS) :
                 (filt_sel == 2'h3) ? 21'(CYC_4MS) : 21'h0;
  assign reached = bypass || (filt_sel == 2'h0) || (cnt >= limit);
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || !raw)
      cnt <= 21'h0;
    else if (!reached)
      cnt <= cnt + 21'h1;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      declared <= 1'b0;
    else
      declared <= raw && reached;
  end
endmodule

// *** src/supply_fault_response.sv ***
// Purpose: per-channel fault reaction, fault line control and log gating
// Assumes: raw fault inputs already compared against thresholds
// Notes:   fault lines are open drain, enable high means pull low
`include "fault_resp_cfg.svh"
module supply_fault_response
  import fault_resp_pkg::*;
#(
  parameter int unsigned CYC_2MS = `FILT_2MS_CYC,
  parameter int unsigned CYC_3MS = `FILT_3MS_CYC,
  parameter int unsigned CYC_4MS = `FILT_4MS_CYC
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  input  wire logic                  cfg_wr,
  input  wire logic [3:0]            cfg_page,
  input  wire logic [31:0]           cfg_wdata,
  output logic      [31:0]           cfg_rdata,
  input  wire logic                  alert_enable,
  input  wire logic                  clear_faults,
  input  wire logic                  master_on,
  input  wire logic                  seq_request,
  input  wire logic                  toff_mode_delayed,
  input  wire logic                  toff_expired,
  input  wire logic                  retry_expired,
  input  wire logic [`NUM_CH*6-1:0]  channel_input_config,
  input  wire logic                  temp_sensor_enable,
  input  wire logic [`NUM_CH-1:0]    ov_raw,
  input  wire logic [`NUM_CH-1:0]    oc_raw,
  input  wire logic [`NUM_CH-1:0]    uv_raw,
  input  wire logic [`NUM_CH-1:0]    pgood,
  input  wire logic [`NUM_CH-1:0]    ton_max_expired,
  input  wire logic                  ot_raw,
  input  wire logic                  cml_fault,
  input  wire logic [`NUM_LINES-1:0] fault_line_in,
  output logic      [`NUM_LINES-1:0] fault_line_oe,
  output logic      [`NUM_LINES-1:0] fault_line_out,
  output logic      [`NUM_CH-1:0]    supply_enable_out,
  output logic      [`NUM_CH-1:0]    ov_status,
  output logic      [`NUM_CH-1:0]    uv_status,
  output logic      [`NUM_CH-1:0]    seq_status,
  output logic                       ot_status,
  output logic                       cml_status,
  output logic                       alert_n,
  output logic      [`NUM_CH-1:0]    log_request,
  output logic      [`NUM_CH*4-1:0]  log_class
);
  // ------------------------------------------------------------
  // configuration storage
  // ------------------------------------------------------------
  logic [31:0]           frc [`NUM_CH];
  ch_state_e             st [`NUM_CH];
  logic [`NUM_CH-1:0]    retry_mode;
  logic [`NUM_CH-1:0]    uv_armed;
  logic [`NUM_CH*4-1:0]  logged;
  logic [`NUM_CH-1:0]    unlatch;
  logic                  master_q;
  wire                   master_toggle;
  wire  [`NUM_CH-1:0]    ov_f;
  wire  [`NUM_CH-1:0]    uv_f;
  wire  [`NUM_CH-1:0]    own_any;
  wire  [`NUM_CH-1:0]    react_fault;
  wire  [`NUM_CH-1:0]    precheck_bad;
  wire  [`NUM_CH-1:0]    line_hit;
  wire  [`NUM_CH-1:0]    seq_flt;
  wire  [`NUM_LINES-1:0] next_line_drive;
  reaction_t             worst_ot;
  logic [`NUM_LINES-1:0] global_assert;
  logic [`NUM_LINES-1:0] sum_drive;

  assign master_toggle = master_on != master_q;
  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      for (int i = 0; i < `NUM_CH; i++)
        frc[i] <= `FRC_RESET;
    else if (cfg_wr)
      frc[cfg_page] <= cfg_wdata & `FRC_RSVD_MASK;
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      cfg_rdata <= 32'h0;
    else
      cfg_rdata <= frc[cfg_page];
  end
  // worst global temperature reaction: latch beats retry beats others
  always_comb
  begin
    worst_ot = REACT_NONE;
    global_assert = '0;
    sum_drive = '0;
    for (int i = 0; i < `NUM_CH; i++)
    begin
      if (frc[i][`FRC_GLOBAL_BIT])
      begin
        global_assert = global_assert | frc[i][`FRC_ASSERT_LSB +: 4];
        if (frc[i][`FRC_OT_LSB +: 2] == REACT_LATCH)
          worst_ot = REACT_LATCH;
        else if (frc[i][`FRC_OT_LSB +: 2] == REACT_RETRY && worst_ot != REACT_LATCH)
          worst_ot = REACT_RETRY;
      end
      if (st[i] == ST_HOLD)
        sum_drive = sum_drive | frc[i][`FRC_ASSERT_LSB +: 4];
    end
  end
  // ------------------------------------------------------------
  // per-channel detection and reaction
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `NUM_CH; g++)
    begin : gen_ch
      wire [5:0]  sel = channel_input_config[g*6 +: 6];
      wire        volt_mon = (sel == `SEL_VOLT_SEQ) || (sel == `SEL_VOLT);
      wire        curr_mon = sel == `SEL_CURR;
      wire        ovoc_raw = (volt_mon && ov_raw[g]) || (curr_mon && oc_raw[g]);
      wire        glob = frc[g][`FRC_GLOBAL_BIT];
      wire        ot_f = temp_sensor_enable && ot_raw;
      wire reaction_t r_ov = frc[g][`FRC_OV_LSB +: 2];
      wire reaction_t r_uv = curr_mon ? REACT_NONE : reaction_t'(frc[g][`FRC_UV_LSB +: 2]);
      wire reaction_t r_sq = curr_mon ? REACT_NONE : reaction_t'(frc[g][`FRC_SEQ_LSB +: 2]);
      // worst global reaction on global channels
      wire reaction_t r_ot = glob ? worst_ot : reaction_t'(frc[g][`FRC_OT_LSB +: 2]);
      wire act_ov = r_ov == REACT_LATCH || r_ov == REACT_RETRY;
      wire act_uv = r_uv == REACT_LATCH || r_uv == REACT_RETRY;
      wire act_sq = r_sq == REACT_LATCH || r_sq == REACT_RETRY;
      wire act_ot = r_ot == REACT_LATCH || r_ot == REACT_RETRY;
      excursion_filter #(
        .CYC_2MS (CYC_2MS),
        .CYC_3MS (CYC_3MS),
        .CYC_4MS (CYC_4MS)
      ) u_ov (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .filt_sel (frc[g][`FRC_FILT_LSB +: 2]),
        .bypass   (1'b0),
        .raw      (ovoc_raw),
        .declared (ov_f[g])
      );
      // uv only once armed by power good
      excursion_filter #(
        .CYC_2MS (CYC_2MS),
        .CYC_3MS (CYC_3MS),
        .CYC_4MS (CYC_4MS)
      ) u_uv (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .filt_sel (frc[g][`FRC_FILT_LSB +: 2]),
        .bypass   (1'b0),
        .raw      (volt_mon && uv_armed[g] && uv_raw[g]),
        .declared (uv_f[g])
      );
      // turn-on timeout only while sequencing on, select 10h
      // timeout without power good counts as a sequencing fault at turn-on
      assign seq_flt[g] = (sel == `SEL_VOLT_SEQ) && seq_request && supply_enable_out[g] &&
                          !pgood[g] && ton_max_expired[g];
      assign precheck_bad[g] = (act_ov && ovoc_raw) || (act_ot && ot_f);
      assign own_any[g] = precheck_bad[g] || (act_uv && uv_f[g]) || (act_sq && seq_flt[g]);
      assign react_fault[g] = (act_ov && ov_f[g]) || (act_uv && uv_f[g]) ||
                              (act_sq && seq_flt[g]) || (act_ot && ot_f);
      // only global channels obey selected lines
      assign line_hit[g] = glob && |(frc[g][`FRC_RESPOND_LSB +: 4] & ~fault_line_in);
      wire retry_pick = (act_ov && ov_f[g] && r_ov == REACT_RETRY) ||
                        (act_uv && uv_f[g] && r_uv == REACT_RETRY) ||
                        (act_sq && seq_flt[g] && r_sq == REACT_RETRY) ||
                        (act_ot && ot_f && r_ot == REACT_RETRY);
      wire [3:0] cls = {ot_f, seq_flt[g], uv_f[g], ov_f[g]};
      wire [3:0] cls_act = {act_ot || r_ot == REACT_CONT, act_sq || r_sq == REACT_CONT,
                            act_uv || r_uv == REACT_CONT, act_ov || r_ov == REACT_CONT};
      // log when bit 15 set and reaction is not none
      // one entry per class until cleared
      wire [3:0] new_log = cls & cls_act & ~logged[g*4 +: 4] & {4{frc[g][`FRC_LOG_BIT]}};
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
          logged[g*4 +: 4] <= 4'h0;
        else
          logged[g*4 +: 4] <= (clear_faults ? 4'h0 : logged[g*4 +: 4]) | new_log;
      end
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          log_request[g] <= 1'b0;
          log_class[g*4 +: 4] <= 4'h0;
        end
        else
        begin
          log_request[g] <= |new_log;
          log_class[g*4 +: 4] <= new_log;
        end
      end
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n || !supply_enable_out[g])
          uv_armed[g] <= 1'b0;
        else if (pgood[g])
          uv_armed[g] <= 1'b1;
      end
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          ov_status[g] <= 1'b0;
          uv_status[g] <= 1'b0;
          seq_status[g] <= 1'b0;
        end
        else
        begin
          ov_status[g] <= ov_f[g] || (ov_status[g] && !clear_faults);
          uv_status[g] <= uv_f[g] || (uv_status[g] && !clear_faults);
          seq_status[g] <= seq_flt[g] || (seq_status[g] && !clear_faults);
        end
      end
      // channel state machine
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
        begin
          st[g] <= ST_OFF;
          retry_mode[g] <= 1'b0;
          unlatch[g] <= 1'b0;
          supply_enable_out[g] <= 1'b0;
        end
        else
        begin
          case (st[g])
            ST_OFF:
            begin
              // no enable while a fault or line is present
              // wait for monitored lines to release
              if (master_on && seq_request && !own_any[g] && !line_hit[g])
              begin
                st[g] <= ST_ON;
                supply_enable_out[g] <= 1'b1;
              end
            end
            ST_ON:
            begin
              // local faults turn this channel off directly, or at toff_expired when turn-off is delayed
              // without delayed turn-off, global faults only assert lines, then obey them
              // line hit drops enable, now or after delay
              if (!master_on)
              begin
                st[g] <= ST_OFF;
                supply_enable_out[g] <= 1'b0;
              end
              else if (react_fault[g])
              begin
                // hold keeps lines driven and channel off; a global channel goes off only on a line hit
                st[g] <= toff_mode_delayed ? ST_DELAY : ST_HOLD;
                supply_enable_out[g] <= toff_mode_delayed || glob;
                retry_mode[g] <= retry_pick;
              end
              else if (line_hit[g])
              begin
                st[g] <= toff_mode_delayed ? ST_DELAY : ST_OFF;
                supply_enable_out[g] <= toff_mode_delayed;
                retry_mode[g] <= 1'b0;
              end
            end
            ST_DELAY:
            begin
              if (toff_expired && !(glob && !line_hit[g] && react_fault[g]))
              begin
                st[g] <= (react_fault[g] || retry_mode[g]) ? ST_HOLD : ST_OFF;
                supply_enable_out[g] <= 1'b0;
              end
            end
            ST_HOLD:
            begin
              if (!glob || line_hit[g])
                supply_enable_out[g] <= 1'b0;
              // latched channel waits for master toggle
              // lines stay while a fault persists
              // retry releases lines once faults cleared
              unlatch[g] <= (unlatch[g] || master_toggle) && own_any[g];
              if ((unlatch[g] || master_toggle || (retry_mode[g] && retry_expired)) &&
                  !own_any[g])
                st[g] <= ST_OFF;
            end
            default:
            begin
              st[g] <= ST_OFF;
              supply_enable_out[g] <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate
  // ------------------------------------------------------------
  // shared fault lines and alert
  // ------------------------------------------------------------
  // temperature latch/retry drives every global assert line
  // communication faults never reach the lines
  assign next_line_drive = sum_drive |
    ((temp_sensor_enable && ot_raw &&
      (worst_ot == REACT_LATCH || worst_ot == REACT_RETRY)) ? global_assert : 4'h0);
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      fault_line_oe <= 4'h0;
      fault_line_out <= 4'h0;
      master_q <= 1'b0;
    end
    else
    begin
      fault_line_oe <= next_line_drive;
      fault_line_out <= 4'h0;
      master_q <= master_on;
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ot_status <= 1'b0;
      cml_status <= 1'b0;
      alert_n <= 1'b1;
    end
    else
    begin
      ot_status <= (temp_sensor_enable && ot_raw) || (ot_status && !clear_faults);
      cml_status <= cml_fault || (cml_status && !clear_faults);
      alert_n <= !(alert_enable && (|ov_status || |uv_status || |seq_status ||
                                    ot_status || cml_status));
    end
  end
endmodule

// *** tb/sfr_monitor.sv ***
// Purpose: port checker for supply_fault_response
// Assumes: one clock, synchronous active-low reset
// Notes:   sees only the top ports, so checks stay config-blind
`include "fault_resp_cfg.svh"
module sfr_monitor (
  input wire logic                  ref_clk,
  input wire logic                  rst_n,
  input wire logic                  cfg_wr,
  input wire logic [3:0]            cfg_page,
  input wire logic [31:0]           cfg_wdata,
  input wire logic [31:0]           cfg_rdata,
  input wire logic                  alert_enable,
  input wire logic                  clear_faults,
  input wire logic [`NUM_LINES-1:0] fault_line_oe,
  input wire logic [`NUM_LINES-1:0] fault_line_out,
  input wire logic [`NUM_CH-1:0]    supply_enable_out,
  input wire logic [`NUM_CH-1:0]    ov_status,
  input wire logic [`NUM_CH-1:0]    uv_status,
  input wire logic [`NUM_CH-1:0]    seq_status,
  input wire logic                  ot_status,
  input wire logic                  cml_status,
  input wire logic                  alert_n,
  input wire logic [`NUM_CH-1:0]    log_request
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence s_cfg_write;
    cfg_wr ##1 (!cfg_wr && $stable(cfg_page));
  endsequence
  sequence s_alert_cause;
    $rose(|{ov_status, uv_status, seq_status, ot_status, cml_status}) ##0 alert_enable [*2];
  endsequence
  property p_reset_quiet;
    rst_n && !$past(rst_n) |-> supply_enable_out == '0 && fault_line_oe == '0 && alert_n;
  endproperty
  property p_line_out_zero;
    fault_line_out == '0;
  endproperty
  property p_rdata_rsvd;
    (cfg_rdata & ~`FRC_RSVD_MASK) == 32'h0000_0000;
  endproperty
  property p_rdata_wr;
    s_cfg_write |=> cfg_rdata == ($past(cfg_wdata, 2) & `FRC_RSVD_MASK);
  endproperty
  property p_alert_on_status;
    s_alert_cause |-> ##[0:1] !alert_n;
  endproperty
  property p_alert_masked;
    !alert_enable && !$past(alert_enable) |-> alert_n;
  endproperty
  property p_status_sticky;
    $past(rst_n) && |(~ov_status & $past(ov_status)) |-> $past(clear_faults)
      || $past(clear_faults, 2);
  endproperty
  property p_log_pulse;
    (log_request & $past(log_request)) == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");
  a_line_out_zero: assert property (p_line_out_zero) else $error("fault line data not 0");
  a_rdata_rsvd: assert property (p_rdata_rsvd) else $error("reserved bits read nonzero");
  a_rdata_wr: assert property (p_rdata_wr) else $error("written word not read back");
  a_alert_on_status: assert property (p_alert_on_status) else $error("alert missing");
  a_alert_masked: assert property (p_alert_masked) else $error("alert while disabled");
  a_status_sticky: assert property (p_status_sticky) else $error("status lost");
  a_log_pulse: assert property (p_log_pulse) else $error("log request too long");
endmodule

// *** tb/fault_line_bus.sv ***
// Purpose: shared open-drain fault lines with a peer device on them
// Assumes: pull-up on every line
// Notes:   peer_pull stands in for channels of other devices
module fault_line_bus (
  input  wire logic [3:0] fault_line_oe,
  input  wire logic [3:0] peer_pull,
  output logic      [3:0] fault_line_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // wired and
  // ----------------------------------------
  // line low while any party pulls
  assign fault_line_in = ~(fault_line_oe | peer_pull);
endmodule

// *** tb/supply_fault_response_tb.sv ***
// Purpose: self-checking bench for supply_fault_response
// Assumes: filter counts shortened to 20/30/40 cycles
// Notes:   ch2 local latch, ch3 local none, ch5 global on line 1
`include "fault_resp_cfg.svh"
module supply_fault_response_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, alert_enable = 1'b1;
  logic clear_faults = 1'b0, master_on = 1'b0, seq_request = 1'b0;
  logic toff_mode_delayed = 1'b0, toff_expired = 1'b0, retry_expired = 1'b0;
  logic temp_sensor_enable = 1'b1, ot_raw = 1'b0, cml_fault = 1'b0, alert_n;
  logic [3:0] cfg_page = 4'h0, peer_pull = 4'h0, fault_line_in, fault_line_oe, fault_line_out;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, rd;
  logic [95:0] channel_input_config = {16{`SEL_VOLT}};
  logic [15:0] ov_raw = 16'h0, oc_raw = 16'h0, uv_raw = 16'h0, pgood = 16'hffff;
  logic [15:0] ton_max_expired = 16'h0, supply_enable_out, ov_status, uv_status;
  logic [15:0] seq_status, log_request;
  logic ot_status, cml_status;
  logic [63:0] log_class;
  int error_cnt = 0, checks_done = 0;
  int log_cnt [16];
  always #2 ref_clk = ~ref_clk;
  supply_fault_response #(.CYC_2MS(20), .CYC_3MS(30), .CYC_4MS(40)) uut (
    .ref_clk, .rst_n, .cfg_wr, .cfg_page, .cfg_wdata, .cfg_rdata, .alert_enable,
    .clear_faults, .master_on, .seq_request, .toff_mode_delayed, .toff_expired,
    .retry_expired, .channel_input_config, .temp_sensor_enable, .ov_raw, .oc_raw,
    .uv_raw, .pgood, .ton_max_expired, .ot_raw, .cml_fault, .fault_line_in,
    .fault_line_oe, .fault_line_out, .supply_enable_out, .ov_status, .uv_status,
    .seq_status, .ot_status, .cml_status, .alert_n, .log_request, .log_class);
  fault_line_bus far (.fault_line_oe, .peer_pull, .fault_line_in);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  always @(posedge ref_clk)
    for (int i = 0; i < 16; i++)
      if (log_request[i] === 1'b1)
        log_cnt[i]++;
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic cfg_write(input logic [3:0] pg, input logic [31:0] d);
    @(negedge ref_clk);
    cfg_wr = 1'b1;
    cfg_page = pg;
    cfg_wdata = d;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
  endtask
  task automatic cfg_read(input logic [3:0] pg, output logic [31:0] d);
    @(negedge ref_clk);
    cfg_page = pg;
    cycles(2);
    d = cfg_rdata;
  endtask
  // bounded wait: a channel that never comes back must not hang the run
  task automatic wait_en(input int ch, input logic v);
    for (int i = 0; i < 200 && supply_enable_out[ch] !== v; i++)
      cycles(1);
    chk($sformatf("enable %0d", ch), {31'h0, v}, {31'h0, supply_enable_out[ch]});
  endtask
  task automatic ov_pulse(input int ch, input int n);
    ov_raw[ch] = 1'b1;
    cycles(n);
    ov_raw[ch] = 1'b0;
    cycles(6);
  endtask
  task automatic power_up();
    seq_request = 1'b1;
    wait_en(2, 1'b1);
    wait_en(3, 1'b1);
    wait_en(5, 1'b1);
    seq_request = 1'b0;
  endtask
  task automatic pulse_clear();
    clear_faults = 1'b1;
    cycles(1);
    clear_faults = 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_cfg();
    cfg_read(4'h0, rd);
    chk("reset word", `FRC_RESET, rd);
    chk("reset enables", 32'h0, {16'h0, supply_enable_out});
    cfg_write(4'h7, 32'hffff_ffff);
    cfg_write(4'h8, 32'h1234_5678);
    cfg_read(4'h7, rd);
    chk("word 7", `FRC_RSVD_MASK, rd);
    cfg_read(4'h8, rd);
    chk("word 8", 32'h1234_5678 & `FRC_RSVD_MASK, rd);
    cfg_write(4'h7, 32'h0);
    cfg_write(4'h8, 32'h0);
  endtask
  task automatic t_latch();
    ov_pulse(2, 3);
    chk("ch2 off", 32'h0, {31'h0, supply_enable_out[2]});
    chk("lines", 32'h1, {28'h0, fault_line_oe});
    chk("ov status", 32'h1, {31'h0, ov_status[2]});
    chk("alert", 32'h0, {31'h0, alert_n});
    chk("log first", 1, log_cnt[2]);
    ov_pulse(2, 3);
    chk("held off", 32'h1, {27'h0, supply_enable_out[2], fault_line_oe});
    chk("log repeat", 1, log_cnt[2]);
    pulse_clear();
    ov_pulse(2, 3);
    chk("log after clear", 2, log_cnt[2]);
    ov_raw[2] = 1'b1;
    master_on = 1'b0;
    cycles(4);
    master_on = 1'b1;
    seq_request = 1'b1;
    cycles(10);
    chk("precheck", 32'h1, {27'h0, supply_enable_out[2], fault_line_oe});
    ov_raw[2] = 1'b0;
    power_up();
    chk("released", 32'h0, {28'h0, fault_line_oe});
  endtask
  task automatic t_none_cml();
    ov_pulse(3, 3);
    chk("ch3 status", 32'h1, {31'h0, ov_status[3]});
    chk("ch3 on, no log", 32'h1, {31'h0, supply_enable_out[3]} + log_cnt[3]);
    cml_fault = 1'b1;
    cycles(2);
    cml_fault = 1'b0;
    cycles(4);
    chk("cml status", 32'h1, {31'h0, cml_status});
    chk("cml no action", 32'h0000_ffff, {fault_line_oe, supply_enable_out});
  endtask
  task automatic t_global();
    peer_pull[1] = 1'b1;
    cycles(5);
    chk("global off", 32'h0, {31'h0, supply_enable_out[5]});
    chk("local ignores", 32'h1, {31'h0, supply_enable_out[2]});
    peer_pull[1] = 1'b0;
    power_up();
    toff_mode_delayed = 1'b1;
    peer_pull[1] = 1'b1;
    cycles(5);
    chk("delay holds", 32'h1, {31'h0, supply_enable_out[5]});
    toff_expired = 1'b1;
    cycles(1);
    toff_expired = 1'b0;
    cycles(3);
    chk("delayed off", 32'h0, {31'h0, supply_enable_out[5]});
    peer_pull[1] = 1'b0;
    toff_mode_delayed = 1'b0;
    power_up();
  endtask
  task automatic t_retry();
    cfg_write(4'h3, 32'h0004_0002);
    ov_raw[3] = 1'b1;
    cycles(6);
    chk("retry off", 32'h4, {27'h0, supply_enable_out[3], fault_line_oe});
    retry_expired = 1'b1;
    cycles(3);
    chk("retry waits", 32'h4, {27'h0, supply_enable_out[3], fault_line_oe});
    ov_raw[3] = 1'b0;
    seq_request = 1'b1;
    cycles(4);
    retry_expired = 1'b0;
    seq_request = 1'b0;
    chk("retry back", 32'h10, {27'h0, supply_enable_out[3], fault_line_oe});
  endtask
  task automatic t_filter();
    cfg_write(4'h3, 32'h0000_9000);
    pulse_clear();
    ov_pulse(3, 10);
    chk("short excursion", 32'h0, {31'h0, ov_status[3]});
    ov_pulse(3, 30);
    chk("long excursion", 32'h1, {31'h0, ov_status[3]});
    alert_enable = 1'b0;
    cycles(3);
    chk("alert masked", 32'h1, {31'h0, alert_n});
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    for (int i = 0; i < 16; i++)
      log_cnt[i] = 0;
    cycles(5);
    rst_n = 1'b1;
    t_reset_cfg();
    cfg_write(4'h2, 32'h0001_8001);
    cfg_write(4'h3, 32'h0000_8000);
    cfg_write(4'h5, 32'h0202_4000);
    master_on = 1'b1;
    power_up();
    t_latch();
    t_none_cml();
    t_global();
    t_retry();
    t_filter();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end
endmodule
bind supply_fault_response sfr_monitor mon (.ref_clk, .rst_n, .cfg_wr, .cfg_page, .cfg_wdata,
  .cfg_rdata, .alert_enable, .clear_faults, .fault_line_oe, .fault_line_out,
  .supply_enable_out, .ov_status, .uv_status, .seq_status, .ot_status, .cml_status,
  .alert_n, .log_request);
